// [dmsh_pkg.sv]
`default_nettype none
package dmsh_pkg;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_MODE = 4'h7;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int BIT_EN = 0;
  localparam int BIT_SEL_LO = 1;
  localparam int BIT_TH_LO = 3;
  localparam int BIT_TC_POL = 5;
  localparam int BIT_ACK_POL = 6;
  localparam int BIT_REQ_POL = 7;
  localparam logic [1:0] SEL_RD_IN = 2'h0;
  localparam logic [1:0] SEL_WR_IN = 2'h1;
  localparam int SYNC_W = 17;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 17'h1e000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  typedef enum {CYC_IDLE, CYC_CPU_RD, CYC_CPU_WR, CYC_M2D, CYC_D2M} dmsh_cyc_t;
endpackage : dmsh_pkg
`default_nettype wire

// [dmsh_dma_mode_select.sv]
`timescale 1ns/1ps
`default_nettype none
module dmsh_dma_mode_select import dmsh_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] host_address_lines,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic dma_acknowledge,
  input wire logic terminal_count,
  output logic dma_request,
  output logic terminal_count_seen,
  output logic [1:0] dma_fifo_threshold,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready
);
  // ==========================================================
  // pin synchronisers
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, stab_reg, stab_next;
  assign raw = {chip_select_n, read_strobe_n, write_strobe_n, dma_acknowledge,
                terminal_count, host_address_lines, data_in};
  // a bit only moves once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_stab
      always_comb begin
        stab_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : stab_reg[gi];
      end
    end
  endgenerate
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_reg <= SYNC_RESET;
      s2_reg <= SYNC_RESET;
      s3_reg <= SYNC_RESET;
      stab_reg <= SYNC_RESET;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stab_reg <= stab_next;
    end
  end
  logic cs_act, rd_act, wr_act, ack_pin, tc_pin;
  logic [3:0] addr_s;
  logic [7:0] din_s;
  assign cs_act = ~stab_reg[16];
  assign rd_act = ~stab_reg[15];
  assign wr_act = ~stab_reg[14];
  assign ack_pin = stab_reg[13];
  assign tc_pin = stab_reg[12];
  assign addr_s = stab_reg[11:8];
  assign din_s = stab_reg[7:0];
  // ==========================================================
  // mode register decode
  logic [7:0] mode_reg, mode_next;
  logic dma_en, ack_act, tc_act;
  logic [1:0] sel;
  assign dma_en = mode_reg[BIT_EN];
  assign sel = mode_reg[BIT_SEL_LO+1:BIT_SEL_LO];
  assign ack_act = mode_reg[BIT_ACK_POL] ? ~ack_pin : ack_pin;
  assign tc_act = mode_reg[BIT_TC_POL] ? tc_pin : ~tc_pin;
  // reserved select codes map no single-address cycle here
  function automatic dmsh_cyc_t dma_kind(input logic [1:0] s, input logic rd);
    dmsh_cyc_t k;
    k = CYC_IDLE;
    if (s == SEL_RD_IN) begin
      k = rd ? CYC_M2D : CYC_D2M;
    end else if (s == SEL_WR_IN) begin
      k = rd ? CYC_D2M : CYC_M2D;
    end
    return k;
  endfunction : dma_kind
  // ==========================================================
  // bus cycle tracking
  dmsh_cyc_t cyc_reg, cyc_next;
  logic [7:0] tx0_reg, tx0_next, tx1_reg, tx1_next;
  logic v0_reg, v0_next, v1_reg, v1_next;
  logic [7:0] rdr_reg, rdr_next;
  logic rfull_reg, rfull_next, rx_ready_reg;
  logic [7:0] dout_reg, dout_next;
  logic oe_reg, oe_next, req_reg, req_next, tcs_reg, tcs_next, tc_old_reg;
  logic push, pop_rx, strobe, release_cyc;
  logic [7:0] push_data;
  assign strobe = rd_act | wr_act;
  always_comb begin
    cyc_next = cyc_reg;
    mode_next = mode_reg;
    push = 1'b0;
    push_data = din_s;
    pop_rx = 1'b0;
    release_cyc = (cyc_reg != CYC_IDLE) && !strobe;
    unique case (cyc_reg)
      CYC_IDLE: begin
        // DMA only counts while enabled; otherwise the select field is moot
        if (strobe && dma_en && ack_act) begin
          cyc_next = dma_kind(sel, rd_act);
        end else if (strobe && cs_act) begin
          cyc_next = rd_act ? CYC_CPU_RD : CYC_CPU_WR;
        end
      end
      CYC_CPU_RD: begin
        if (release_cyc) begin
          cyc_next = CYC_IDLE;
          pop_rx = (addr_s == ADDR_DATA);
        end
      end
      CYC_CPU_WR: begin
        if (release_cyc) begin
          cyc_next = CYC_IDLE;
          push = (addr_s == ADDR_DATA);
          if (addr_s == ADDR_MODE) begin
            mode_next = din_s;
          end
        end
      end
      CYC_M2D: begin
        // address lines play no part: data register only
        if (release_cyc) begin
          cyc_next = CYC_IDLE;
          push = 1'b1;
        end
      end
      CYC_D2M: begin
        if (release_cyc) begin
          cyc_next = CYC_IDLE;
          pop_rx = 1'b1;
        end
      end
    endcase
  end
  // ==========================================================
  // transmit buffer (two entries) and receive holding register
  always_comb begin
    tx0_next = tx0_reg;
    tx1_next = tx1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    if (v0_reg && tx_ready) begin
      tx0_next = tx1_reg;
      v0_next = v1_reg;
      v1_next = 1'b0;
    end
    // a push into a full buffer is dropped unless tx_ready pops an entry that cycle; by then the request is on only while rfull_reg is set
    if (push && !(v1_reg && !(v0_reg && tx_ready))) begin
      if (v0_next) begin
        tx1_next = push_data;
        v1_next = 1'b1;
      end else begin
        tx0_next = push_data;
        v0_next = 1'b1;
      end
    end
    rdr_next = rdr_reg;
    rfull_next = rfull_reg && !pop_rx;
    if (rx_valid && rx_ready_reg) begin
      rdr_next = rx_data;
      rfull_next = 1'b1;
    end
    oe_next = (cyc_next == CYC_CPU_RD) || (cyc_next == CYC_D2M);
    dout_next = DATA_RESET;
    if (cyc_next == CYC_D2M ||
        (cyc_next == CYC_CPU_RD && addr_s == ADDR_DATA)) begin
      dout_next = rdr_reg;
    end else if (cyc_next == CYC_CPU_RD && addr_s == ADDR_MODE) begin
      dout_next = mode_reg;
    end
    // request while there is room to fill or data to drain
    req_next = mode_reg[BIT_REQ_POL] ~^
               (dma_en && (!v1_reg || rfull_reg));
    tcs_next = dma_en && tc_act && !tc_old_reg;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET;
      cyc_reg <= CYC_IDLE;
      tx0_reg <= DATA_RESET;
      tx1_reg <= DATA_RESET;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
      rdr_reg <= DATA_RESET;
      rfull_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      dout_reg <= DATA_RESET;
      oe_reg <= 1'b0;
      req_reg <= 1'b1;
      tcs_reg <= 1'b0;
      tc_old_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cyc_reg <= cyc_next;
      tx0_reg <= tx0_next;
      tx1_reg <= tx1_next;
      v0_reg <= v0_next;
      v1_reg <= v1_next;
      rdr_reg <= rdr_next;
      rfull_reg <= rfull_next;
      rx_ready_reg <= !rfull_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      req_reg <= req_next;
      tcs_reg <= tcs_next;
      tc_old_reg <= tc_act;
    end
  end
  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign dma_request = req_reg;
  assign terminal_count_seen = tcs_reg;
  assign dma_fifo_threshold = mode_reg[BIT_TH_LO+1:BIT_TH_LO];
  assign tx_data = tx0_reg;
  assign tx_valid = v0_reg;
  assign rx_ready = rx_ready_reg;
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_dma_start;
    cyc_reg == CYC_IDLE && strobe && dma_en && ack_act;
  endsequence
  sequence s_m2d_done;
    cyc_reg == CYC_M2D && !strobe && !v1_reg;
  endsequence
  // reset is the only moment this check must not be disabled
  a_reset_mode_clear: assert property (
    disable iff (1'b0) sys_rst |=> mode_reg == MODE_RESET)
    else $error("mode register not cleared by reset");
  a_enable_gates_dma: assert property (
    (cyc_reg == CYC_IDLE && strobe && ack_act && !dma_en) |=>
    cyc_reg != CYC_M2D && cyc_reg != CYC_D2M)
    else $error("dma cycle taken while disabled");
  a_sel0_read_m2d: assert property (
    s_dma_start ##0 (sel == SEL_RD_IN && rd_act) |=> cyc_reg == CYC_M2D)
    else $error("select zero read not memory to device");
  a_sel0_write_d2m: assert property (
    s_dma_start ##0 (sel == SEL_RD_IN && !rd_act) |=> cyc_reg == CYC_D2M)
    else $error("select zero write not device to memory");
  a_sel1_swapped: assert property (
    s_dma_start ##0 (sel == SEL_WR_IN) |=>
    cyc_reg == ($past(rd_act) ? CYC_D2M : CYC_M2D))
    else $error("select one strobes not swapped");
  a_dma_addr_ignored: assert property (
    (cyc_reg == CYC_M2D && !strobe) |=> $stable(mode_reg))
    else $error("dma cycle touched the mode register");
  // request is registered, so it follows the polarity one cycle late
  a_request_polarity: assert property (
    (!dma_en && $stable(mode_reg)) |=>
    dma_request == !$past(mode_reg[BIT_REQ_POL]))
    else $error("request idle level wrong for polarity");
  a_ack_decode: assert property (
    ack_act == (ack_pin ^ mode_reg[BIT_ACK_POL]))
    else $error("acknowledge polarity decode wrong");
  a_threshold_field: assert property (
    dma_fifo_threshold == mode_reg[BIT_TH_LO+1:BIT_TH_LO])
    else $error("threshold field not presented");
  a_m2d_pushes_tx: assert property (
    s_m2d_done |=>
    v0_reg && (v1_reg ? tx1_reg : tx0_reg) == $past(din_s))
    else $error("memory to device data not in transmit buffer");
  a_d2m_drives_rdr: assert property (
    (cyc_next == CYC_D2M) |=> data_oe && data_out == $past(rdr_reg))
    else $error("device to memory does not drive receive data");
endmodule : dmsh_dma_mode_select
`default_nettype wire

// [dmsh_external_dma_controller_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dmsh_external_dma_controller_model (
  input wire logic clock,
  input wire logic [7:0] data_out,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [3:0] host_address_lines,
  output logic [7:0] data_in,
  output logic dma_acknowledge
);
  // ========================================
  // host bus pins and acknowledge
  logic ack_on = 1'b0;
  logic ack_inv = 1'b0;
  // pin level follows the polarity the device is told to expect
  assign dma_acknowledge = ack_on ^ ack_inv;
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_address_lines = 4'h0;
    data_in = 8'hff;
  end
  // pins are asynchronous to the device, so hold each phase long
  // enough for its three-flop synchroniser
  task automatic cycle(input logic cs, input logic ack, input logic rd,
      input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    #1;
    chip_select_n = ~cs;
    ack_on = ack;
    host_address_lines = a;
    data_in = d;
    if (rd) read_strobe_n = 1'b0;
    else write_strobe_n = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    q = data_out;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    // write data is taken at the synced release, keep it a while
    repeat (6) @(posedge clock);
    #1;
    chip_select_n = 1'b1;
    ack_on = 1'b0;
    host_address_lines = ~a;
    data_in = ~d;
    repeat (2) @(posedge clock);
    // hand back off the edge so callers never race the flops
    #1;
  endtask : cycle
endmodule : dmsh_external_dma_controller_model
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic tx_ready = 1'b0;
  logic rx_valid = 1'b0;
  logic terminal_count = 1'b1;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] q, din, dout, txd;
  logic cs_n, rd_n, wr_n, ack, oe, req, tcs, txv, rxr;
  logic [3:0] addr;
  logic [1:0] th;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int tc_pulses = 0;
  logic oe_seen = 1'b0;
  always #2.5 clock = ~clock;
  dmsh_dma_mode_select u_dmsh_dma_mode_select (.clock(clock),
    .sys_rst(sys_rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .host_address_lines(addr), .data_in(din),
    .data_out(dout), .data_oe(oe), .dma_acknowledge(ack),
    .terminal_count(terminal_count), .dma_request(req),
    .terminal_count_seen(tcs), .dma_fifo_threshold(th), .tx_data(txd),
    .tx_valid(txv), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rxr));
  dmsh_external_dma_controller_model u_dmsh_external_dma_controller_model (.clock(clock), .data_out(dout),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .host_address_lines(addr), .data_in(din), .dma_acknowledge(ack));
  // ========================================
  // checking and closing
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic cmp8(input string n, input logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : cmp8
  task automatic cmp1(input string n, input logic e, input logic s);
    cmp8(n, {7'h00, e}, {7'h00, s});
  endtask : cmp1
  always @(posedge clock) begin
    cyc++;
    if (tcs === 1'b1) tc_pulses++;
    if (oe === 1'b1) oe_seen = 1'b1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  // ========================================
  // stream side helpers
  task automatic rx_push(input logic [7:0] d);
    int k;
    k = 0;
    #1;
    rx_valid = 1'b1;
    rx_data = d;
    while (rxr !== 1'b1 && k < 50) begin
      @(posedge clock);
      #1;
      k++;
    end
    cmp1("rx_ready", 1'b1, rxr);
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
    rx_data = ~d;
  endtask : rx_push
  task automatic take(input logic [7:0] e);
    int k;
    k = 0;
    @(posedge clock);
    #1;
    tx_ready = 1'b1;
    while (txv !== 1'b1 && k < 20) begin
      @(posedge clock);
      #1;
      k++;
    end
    cmp1("tx_valid", 1'b1, txv);
    cmp8("tx_data", e, txd);
    @(posedge clock);
    #1;
    tx_ready = 1'b0;
  endtask : take
  task automatic wr_mode(input logic [7:0] v);
    u_dmsh_external_dma_controller_model.cycle(1'b1, 1'b0, 1'b0, 4'h7, v, q);
  endtask : wr_mode
  // ========================================
  // scenarios
  task automatic t_reset();
    u_dmsh_external_dma_controller_model.cycle(1'b1, 1'b0, 1'b1, 4'h7, 8'h00, q);
    cmp8("mode", 8'h00, q);
    cmp1("dma_request", 1'b1, req);
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b1, 4'h0, 8'h11, q);
    cmp1("tx_valid", 1'b0, txv);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_sel0();
    wr_mode(8'h19);
    cmp8("threshold", 8'h03, {6'h00, th});
    cmp1("dma_request", 1'b0, req);
    oe_seen = 1'b0;
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b1, 4'h5, 8'ha5, q);
    cmp1("tx_valid", 1'b1, txv);
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b1, 4'h0, 8'h01, q);
    // buffer is full now, this one must be dropped
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b1, 4'h0, 8'h02, q);
    cmp1("dma_request", 1'b1, req);
    cmp1("data_oe", 1'b0, oe_seen);
    take(8'ha5);
    take(8'h01);
    cmp1("tx_valid", 1'b0, txv);
    rx_push(8'h3c);
    oe_seen = 1'b0;
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b0, 4'h9, 8'h00, q);
    cmp8("dma_read", 8'h3c, q);
    cmp1("data_oe", 1'b1, oe_seen);
    $display("t_sel0 done");
  endtask : t_sel0
  task automatic t_sel1();
    wr_mode(8'h03);
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b0, 4'h3, 8'h5a, q);
    take(8'h5a);
    rx_push(8'hc3);
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b1, 4'h2, 8'h00, q);
    cmp8("dma_read", 8'hc3, q);
    wr_mode(8'h05);
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b1, 4'h0, 8'h44, q);
    cmp1("tx_valid", 1'b0, txv);
    $display("t_sel1 done");
  endtask : t_sel1
  task automatic t_pol();
    terminal_count = 1'b0;
    wr_mode(8'he3);
    u_dmsh_external_dma_controller_model.ack_inv = 1'b1;
    cmp1("dma_request", 1'b1, req);
    u_dmsh_external_dma_controller_model.cycle(1'b0, 1'b1, 1'b0, 4'h0, 8'h77, q);
    take(8'h77);
    tc_pulses = 0;
    terminal_count = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    terminal_count = 1'b0;
    repeat (10) @(posedge clock);
    cmp8("tc_pulses", 8'h01, tc_pulses[7:0]);
    $display("t_pol done");
  endtask : t_pol
  // reset in mid-run must wipe a mode with every polarity bit set
  task automatic t_mid_reset();
    #1;
    u_dmsh_external_dma_controller_model.ack_inv = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    cmp1("dma_request", 1'b1, req);
    cmp1("rx_ready", 1'b1, rxr);
    u_dmsh_external_dma_controller_model.cycle(1'b1, 1'b0, 1'b1, 4'h7, 8'h00, q);
    cmp8("mode", 8'h00, q);
    $display("t_mid_reset done");
  endtask : t_mid_reset
  initial begin
    repeat (3) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clock);
    t_reset();
    t_sel0();
    t_sel1();
    t_pol();
    t_mid_reset();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
